// >>> owcd_top.sv
// oscillator and watchdog configuration word decoder with wishbone slave
// ****************************************************************
// Overview of operation
// - cksm 1x disables switch and monitor, 01 switch only, 00 both
// - lock-once 1 lets lock set once; 0 set/clear freely, keyed
// - pll source bit 1 feeds primary oscillator, 0 feeds fast rc
// - pll source is decoded and checked whether or not pll drives the system clock
// - secondary mode 1 is crystal, 0 is external digital clock
// - clock out drives only if enabled and primary is off or external
// - primary mode 11 off, 10 high speed, 01 standard, 00 external
// - clock mux 1 uses clock select, 0 forces low-power rc
// - select 10 fast rc if windowed, not on low_power_rc_osc and awake
// - select 00 peripheral clock if not on low_power_rc_osc and awake
// - window width 11 25%, 10 37.5%, 01 50%, 00 75%
// - window disable 1 turns windowing off, 0 turns it on
// - enable 11 always on; 00 disables watchdog and software bit
// - enable 10 hands control to the software enable bit
// - enable 01 runs only while awake; software bit ignored
// - prescaler bit 1 gives 1:128, 0 gives 1:32
// - postscale field gives ratio two to the field value
// ****************************************************************
//
// Implementation choices: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
`include "owcd_map.svh"
module owcd_top
   import owcd_pkg::*;
(
   input  wire logic          mclk,
   input  wire logic          arst_n,
   input  wire logic [15:0]   nvm_osc_word,
   input  wire logic          nvm_osc_prog,
   input  wire logic [15:0]   nvm_wdog_word,
   input  wire logic          nvm_wdog_prog,
   input  wire logic          sys_clk_is_low_power_rc_osc,
   input  wire logic          sys_clk_uses_pll,
   input  wire logic          sleeping,
   input  wire logic          wb_cyc,
   input  wire logic          wb_stb,
   input  wire logic          wb_we,
   input  wire logic [7:0]    wb_adr,
   input  wire logic [3:0]    wb_sel,
   input  wire logic [31:0]   wb_dat_w,
   output logic [31:0]        wb_dat_r,
   output logic               wb_ack,
   output owcd_osc_type       osc_cfg,
   output owcd_wdog_type      wdog_cfg,
   output logic               pin_select_lock,
   output logic               cfg_invalid
);

   // ****************************************************************
   // configuration word capture
   // ****************************************************************
   logic [15:0]        osc_word_q;
   logic [15:0]        wdog_word_q;
   logic               loaded_q;

   // words are caught on the first edge after reset release, so the
   // async reset only ever loads the blank all-ones constant
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         osc_word_q  <= `OWCD_WORD_RESET;
         wdog_word_q <= `OWCD_WORD_RESET;
         loaded_q    <= 1'b0;
      end else if (!loaded_q) begin
         osc_word_q  <= nvm_osc_prog ? nvm_osc_word : `OWCD_WORD_RESET;
         wdog_word_q <= nvm_wdog_prog ? nvm_wdog_word
                                      : `OWCD_WORD_RESET;
         loaded_q    <= 1'b1;
      end
   end

   // ****************************************************************
   // oscillator word fields
   // ****************************************************************
   wire logic [1:0]    cksm_f   = osc_word_q[`OWCD_CKSM_LSB +: 2];
   wire logic          lock1_f  = osc_word_q[`OWCD_LOCK1_BIT];
   wire logic          pllsrc_f = osc_word_q[`OWCD_PLLSRC_BIT];
   wire logic          secondary_osc_f   = osc_word_q[`OWCD_SECONDARY_OSC_BIT];
   wire logic          clock_out_f   = osc_word_q[`OWCD_CLOCK_OUT_BIT];
   wire owcd_primary_osc_mode_type primary_osc_f =
      owcd_primary_osc_mode_type'(osc_word_q[`OWCD_PRIMARY_OSC_LSB +: 2]);

   // ****************************************************************
   // watchdog word fields
   // ****************************************************************
   wire owcd_wdog_clk_type wclk_f =
      owcd_wdog_clk_type'(wdog_word_q[`OWCD_WCLK_LSB +: 2]);
   wire logic          wcmx_f   = wdog_word_q[`OWCD_WCMX_BIT];
   wire logic [1:0]    wwin_f   = wdog_word_q[`OWCD_WWIN_LSB +: 2];
   wire logic          window_disable_f = wdog_word_q[`OWCD_WINDOW_DISABLE_BIT];
   wire owcd_wen_mode_type wen_f =
      owcd_wen_mode_type'(wdog_word_q[`OWCD_WEN_LSB +: 2]);
   wire logic          wpsa_f   = wdog_word_q[`OWCD_WPSA_BIT];
   wire logic [3:0]    wps_f    = wdog_word_q[`OWCD_WPS_LSB +: 4];

   // ****************************************************************
   // wishbone decode
   // ****************************************************************
   wire logic          req      = wb_cyc & wb_stb & ~wb_ack;
   wire logic          wr_req   = req & wb_we;
   wire logic [7:0]    word_adr = {wb_adr[7:2], 2'b00};
   wire logic          hit_osc  = word_adr == `OWCD_OFS_OSC;
   wire logic          hit_wdog = word_adr == `OWCD_OFS_WDOG;
   wire logic          hit_ctrl = word_adr == `OWCD_OFS_CTRL;
   wire logic          hit_key  = word_adr == `OWCD_OFS_KEY;
   wire logic          hit_stat = word_adr == `OWCD_OFS_STAT;
   // only byte lane 0 carries writable bits
   wire logic          wr_ctrl  = wr_req & hit_ctrl & wb_sel[0];
   wire logic          wr_key   = wr_req & hit_key & wb_sel[0];
   wire logic [7:0]    wbyte    = wb_dat_w[7:0];

   // ****************************************************************
   // unlock sequence
   // ****************************************************************
   owcd_key_state_type key_q;
   owcd_key_state_type key_d;

   // two key writes in order arm one control write; any other key
   // value restarts, and the control write itself consumes the arm
   always_comb begin
      key_d = key_q;
      if (wr_key) begin
         if (wbyte == `OWCD_KEY_FIRST) begin
            key_d = OWCD_KEY_ONE;
         end else if (key_q == OWCD_KEY_ONE &&
                      wbyte == `OWCD_KEY_SECOND) begin
            key_d = OWCD_KEY_ARMED;
         end else begin
            key_d = OWCD_KEY_IDLE;
         end
      end else if (wr_ctrl) begin
         key_d = OWCD_KEY_IDLE;
      end
   end

   wire logic          armed    = key_q == OWCD_KEY_ARMED;

   // ****************************************************************
   // pin-select lock and software watchdog enable
   // ****************************************************************
   logic               lock_q;
   logic               lock_d;
   logic               used_q;
   logic               swen_q;
   logic               swen_d;
   wire logic          lock_wr  = wr_ctrl & armed;
   wire logic          lock_val = wbyte[`OWCD_CTRL_LOCK];

   // a set under lock-once is final until reset; clearing needs the
   // key and a free lock policy
   always_comb begin
      lock_d = lock_q;
      if (lock_wr && lock_val && !(lock1_f && used_q)) begin
         lock_d = 1'b1;
      end else if (lock_wr && !lock_val && !lock1_f) begin
         lock_d = 1'b0;
      end
   end

   // with the watchdog disabled by configuration the software bit is
   // held at zero and cannot be set
   always_comb begin
      swen_d = swen_q;
      if (wr_ctrl) begin
         swen_d = wbyte[`OWCD_CTRL_SWEN];
      end
      if (wen_f == OWCD_WEN_OFF) begin
         swen_d = 1'b0;
      end
   end

   // ****************************************************************
   // oscillator decode
   // ****************************************************************
   owcd_osc_type       osc_d;
   wire logic          primary_osc_gone = primary_osc_f == OWCD_PRIMARY_OSC_OFF;
   wire logic          primary_osc_ext  = primary_osc_f == OWCD_PRIMARY_OSC_EXT;

   always_comb begin
      osc_d.clk_switch_en        = ~cksm_f[1];
      osc_d.fail_safe_en         = cksm_f == 2'b00;
      osc_d.pin_select_lock_once = lock1_f;
      osc_d.pll_from_primary     = pllsrc_f;
      osc_d.reference_clock_out_pll_free        = ~sys_clk_uses_pll;
      osc_d.secondary_crystal    = secondary_osc_f;
      osc_d.clock_out            = clock_out_f & (primary_osc_gone | primary_osc_ext);
      osc_d.primary_osc_mode     = primary_osc_f;
   end

   // flags the one combination that software must never program,
   // primary oscillator as pll source with that oscillator absent
   wire logic          invalid_d = pllsrc_f & primary_osc_gone;

   // ****************************************************************
   // watchdog clock selection
   // ****************************************************************
   owcd_wdog_clk_type  wclk_d;
   wire logic          awake_ok  = ~sys_clk_is_low_power_rc_osc & ~sleeping;

   // every fallback lands on the low-power rc, which like the secondary
   // oscillator survives sleep and a system clock already running from it
   always_comb begin
      wclk_d = OWCD_WCLK_LOW_POWER_RC_OSC;
      if (wcmx_f) begin
         case (wclk_f)
            OWCD_WCLK_LOW_POWER_RC_OSC: wclk_d = OWCD_WCLK_LOW_POWER_RC_OSC;
            OWCD_WCLK_SECONDARY_OSC: wclk_d = OWCD_WCLK_SECONDARY_OSC;
            OWCD_WCLK_FRC: begin
               if (!window_disable_f && awake_ok) begin
                  wclk_d = OWCD_WCLK_FRC;
               end
            end
            OWCD_WCLK_PCLK: begin
               if (awake_ok) begin
                  wclk_d = OWCD_WCLK_PCLK;
               end
            end
            default: wclk_d = OWCD_WCLK_LOW_POWER_RC_OSC;
         endcase
      end
   end

   // ****************************************************************
   // watchdog enable, window and timeout
   // ****************************************************************
   logic               run_d;
   logic [2:0]         win_d;

   always_comb begin
      case (wen_f)
         OWCD_WEN_ON:    run_d = 1'b1;
         OWCD_WEN_SW:    run_d = swen_q;
         OWCD_WEN_AWAKE: run_d = ~sleeping;
         OWCD_WEN_OFF:   run_d = 1'b0;
         default:        run_d = 1'b0;
      endcase
   end

   // window share expressed in eighths of the period
   always_comb begin
      case (wwin_f)
         2'b11:   win_d = 3'h2;
         2'b10:   win_d = 3'h3;
         2'b01:   win_d = 3'h4;
         default: win_d = 3'h6;
      endcase
   end

   owcd_wdog_type      wdog_d;
   wire logic [2:0]    pre_log2 = wpsa_f ? `OWCD_PRE_LOG2_HI
                                         : `OWCD_PRE_LOG2_LO;

   // ratios are powers of two, so the product is a sum of exponents;
   // the counter itself lives in the watchdog, not here
   always_comb begin
      wdog_d.clk_src        = wclk_d;
      wdog_d.run            = run_d;
      wdog_d.window_en      = ~window_disable_f;
      wdog_d.window_eighths = win_d;
      wdog_d.prescale_log2  = pre_log2;
      wdog_d.postscale_log2 = wps_f;
      wdog_d.timeout_log2   = {2'b00, pre_log2} + {1'b0, wps_f};
   end

   // ****************************************************************
   // read data
   // ****************************************************************
   logic [31:0]        rdat_d;
   wire logic [31:0]   stat_w = {25'h0000000, loaded_q, armed,
                                 cfg_invalid, pin_select_lock,
                                 wdog_cfg.run, wdog_cfg.clk_src};

   // unmapped addresses still answer, with zero data
   always_comb begin
      if (hit_osc) begin
         rdat_d = {16'h0000, osc_word_q};
      end else if (hit_wdog) begin
         rdat_d = {16'h0000, wdog_word_q};
      end else if (hit_ctrl) begin
         rdat_d = {30'h00000000, lock_q, swen_q};
      end else if (hit_stat) begin
         rdat_d = stat_w;
      end else begin
         rdat_d = 32'h00000000;
      end
   end

   // ****************************************************************
   // state registers
   // ****************************************************************
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         key_q  <= OWCD_KEY_IDLE;
         lock_q <= 1'b0;
         used_q <= 1'b0;
         swen_q <= 1'b0;
      end else begin
         key_q  <= key_d;
         lock_q <= lock_d;
         used_q <= used_q | (lock_d & ~lock_q);
         swen_q <= swen_d;
      end
   end

   // decoded outputs are registered to keep config paths short
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         osc_cfg         <= '0;
         wdog_cfg        <= '0;
         cfg_invalid     <= 1'b0;
         pin_select_lock <= 1'b0;
      end else begin
         osc_cfg         <= osc_d;
         wdog_cfg        <= wdog_d;
         cfg_invalid     <= invalid_d;
         pin_select_lock <= lock_q;
      end
   end

   // one answer per request, ack registered one edge after it; ack drops the cycle after
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         wb_ack   <= 1'b0;
         wb_dat_r <= 32'h00000000;
      end else begin
         wb_ack   <= req;
         wb_dat_r <= req ? rdat_d : 32'h00000000;
      end
   end

endmodule

// >>> owcd_map.svh
// offsets, field positions, reset values and counts of the config decoder
`ifndef OWCD_MAP_SVH
`define OWCD_MAP_SVH
// ****************************************************************
// register byte offsets on the wishbone bus
// ****************************************************************
`define OWCD_OFS_OSC      8'h00
`define OWCD_OFS_WDOG     8'h04
`define OWCD_OFS_CTRL     8'h08
`define OWCD_OFS_KEY      8'h0c
`define OWCD_OFS_STAT     8'h10
// ****************************************************************
// oscillator word fields
// ****************************************************************
`define OWCD_CKSM_LSB     6
`define OWCD_LOCK1_BIT    5
`define OWCD_PLLSRC_BIT   4
`define OWCD_SECONDARY_OSC_BIT     3
`define OWCD_CLOCK_OUT_BIT     2
`define OWCD_PRIMARY_OSC_LSB     0
// ****************************************************************
// watchdog word fields
// ****************************************************************
`define OWCD_WCLK_LSB     13
`define OWCD_WCMX_BIT     11
`define OWCD_WWIN_LSB     8
`define OWCD_WINDOW_DISABLE_BIT   7
`define OWCD_WEN_LSB      5
`define OWCD_WPSA_BIT     4
`define OWCD_WPS_LSB      0
// ****************************************************************
// control register fields, reset values, keys, counts
// ****************************************************************
`define OWCD_CTRL_SWEN    0
`define OWCD_CTRL_LOCK    1
`define OWCD_WORD_RESET   16'hffff
`define OWCD_KEY_FIRST    8'h55
`define OWCD_KEY_SECOND   8'haa
`define OWCD_PRE_LOG2_HI  3'h7
`define OWCD_PRE_LOG2_LO  3'h5
`endif

// >>> owcd_pkg.sv
// types of the oscillator and watchdog configuration decoder
package owcd_pkg;
   typedef enum logic [1:0] {
      OWCD_PRIMARY_OSC_EXT  = 2'b00,
      OWCD_PRIMARY_OSC_STD  = 2'b01,
      OWCD_PRIMARY_OSC_HS   = 2'b10,
      OWCD_PRIMARY_OSC_OFF  = 2'b11
   } owcd_primary_osc_mode_type;
   typedef enum logic [1:0] {
      OWCD_WCLK_PCLK = 2'b00,
      OWCD_WCLK_SECONDARY_OSC = 2'b01,
      OWCD_WCLK_FRC  = 2'b10,
      OWCD_WCLK_LOW_POWER_RC_OSC = 2'b11
   } owcd_wdog_clk_type;
   typedef enum logic [1:0] {
      OWCD_WEN_OFF   = 2'b00,
      OWCD_WEN_AWAKE = 2'b01,
      OWCD_WEN_SW    = 2'b10,
      OWCD_WEN_ON    = 2'b11
   } owcd_wen_mode_type;
   typedef enum logic [1:0] {
      OWCD_KEY_IDLE  = 2'b00,
      OWCD_KEY_ONE   = 2'b01,
      OWCD_KEY_ARMED = 2'b10
   } owcd_key_state_type;
   typedef struct packed {
      logic               clk_switch_en;
      logic               fail_safe_en;
      logic               pin_select_lock_once;
      logic               pll_from_primary;
      logic               reference_clock_out_pll_free;
      logic               secondary_crystal;
      logic               clock_out;
      owcd_primary_osc_mode_type primary_osc_mode;
   } owcd_osc_type;
   typedef struct packed {
      owcd_wdog_clk_type  clk_src;
      logic               run;
      logic               window_en;
      logic [2:0]         window_eighths;
      logic [2:0]         prescale_log2;
      logic [3:0]         postscale_log2;
      logic [4:0]         timeout_log2;
   } owcd_wdog_type;
endpackage

// >>> owcd_top_assertions.sv
// checker on the ports of the config decoder
`timescale 1ns/1ps
module owcd_top_assertions
   import owcd_pkg::*;
(
   input wire logic          mclk,
   input wire logic          arst_n,
   input wire logic          sys_clk_uses_pll,
   input wire logic          sleeping,
   input wire logic          wb_cyc,
   input wire logic          wb_stb,
   input wire logic [31:0]   wb_dat_r,
   input wire logic          wb_ack,
   input wire owcd_osc_type  osc_cfg,
   input wire owcd_wdog_type wdog_cfg,
   input wire logic          pin_select_lock,
   input wire logic          cfg_invalid
);
   logic [1:0] up_q;
   logic       up;
   // decode outputs hold reset, then blank-word values, until two edges after release
   assign up = (up_q == 2'h3);
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         up_q <= 2'h0;
      end else if (!up) begin
         up_q <= up_q + 2'h1;
      end
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!arst_n);
   // ***********************
   // properties
   // ***********************
   a_monitor_needs_switch: assert property (
      osc_cfg.fail_safe_en |-> osc_cfg.clk_switch_en)
      else $error("monitor on without clock switching");
   a_clock_out_gate: assert property (
      osc_cfg.clock_out |->
      osc_cfg.primary_osc_mode inside {OWCD_PRIMARY_OSC_OFF, OWCD_PRIMARY_OSC_EXT})
      else $error("clock out with a crystal primary mode");
   a_reference_clock_out_pll_free: assert property (
      up |-> osc_cfg.reference_clock_out_pll_free == !$past(sys_clk_uses_pll))
      else $error("pll free flag does not follow pll use");
   a_invalid_source: assert property (
      up |-> cfg_invalid == (osc_cfg.pll_from_primary &&
      osc_cfg.primary_osc_mode == OWCD_PRIMARY_OSC_OFF))
      else $error("invalid pll source flag wrong");
   a_window_share: assert property (
      up |-> wdog_cfg.window_eighths inside {3'h2, 3'h3, 3'h4, 3'h6})
      else $error("window share not a legal value");
   a_timeout_sum: assert property (
      up |-> wdog_cfg.prescale_log2 inside {3'h5, 3'h7} &&
      wdog_cfg.timeout_log2 == {2'h0, wdog_cfg.prescale_log2}
      + {1'h0, wdog_cfg.postscale_log2})
      else $error("timeout exponent is not prescale plus postscale");
   a_sleep_fallback: assert property (
      up && $past(sleeping) |->
      wdog_cfg.clk_src inside {OWCD_WCLK_SECONDARY_OSC, OWCD_WCLK_LOW_POWER_RC_OSC})
      else $error("watchdog clock did not fall back in sleep");
   a_lock_once_holds: assert property (
      up && osc_cfg.pin_select_lock_once && $past(pin_select_lock)
      |-> pin_select_lock)
      else $error("lock cleared while lock-once is set");
   a_ack_one_cycle: assert property (
      wb_cyc && wb_stb && !wb_ack |=> wb_ack ##1 !wb_ack)
      else $error("ack not a single pulse one cycle after request");
   a_idle_data_zero: assert property (
      !wb_ack |-> wb_dat_r == 32'h0)
      else $error("read data not zero outside ack");
endmodule
bind owcd_top owcd_top_assertions u_chk (.mclk(mclk), .arst_n(arst_n),
   .sys_clk_uses_pll(sys_clk_uses_pll), .sleeping(sleeping),
   .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_dat_r(wb_dat_r),
   .wb_ack(wb_ack), .osc_cfg(osc_cfg), .wdog_cfg(wdog_cfg),
   .pin_select_lock(pin_select_lock), .cfg_invalid(cfg_invalid));

// >>> owcd_top_bench.sv
// self-checking random bench for the config decoder
`timescale 1ns/1ps
module owcd_top_bench
   import owcd_pkg::*;
   ;
   logic          mclk, arst_n, nvm_osc_prog, nvm_wdog_prog, sleeping;
   logic          sys_clk_is_low_power_rc_osc, sys_clk_uses_pll, wb_cyc, wb_stb, wb_we;
   logic          wb_ack, pin_select_lock, cfg_invalid;
   logic [15:0]   nvm_osc_word, nvm_wdog_word, ow, ww;
   logic [7:0]    wb_adr;
   logic [3:0]    wb_sel;
   logic [31:0]   wb_dat_w, wb_dat_r, rd;
   owcd_osc_type  osc_cfg;
   owcd_wdog_type wdog_cfg;
   int            fails, comparisons;
   owcd_top u_dut (.mclk, .arst_n, .nvm_osc_word, .nvm_osc_prog,
      .nvm_wdog_word, .nvm_wdog_prog, .sys_clk_is_low_power_rc_osc, .sys_clk_uses_pll,
      .sleeping, .wb_cyc, .wb_stb, .wb_we, .wb_adr, .wb_sel, .wb_dat_w,
      .wb_dat_r, .wb_ack, .osc_cfg, .wdog_cfg, .pin_select_lock,
      .cfg_invalid);
   // ***********************
   // expectations
   // ***********************
   function automatic owcd_osc_type exp_osc(input logic [15:0] w,
                                            input logic pll);
      owcd_osc_type e;
      e.clk_switch_en        = ~w[7];
      e.fail_safe_en         = (w[7:6] == 2'b00);
      e.pin_select_lock_once = w[5];
      e.pll_from_primary     = w[4];
      e.reference_clock_out_pll_free        = ~pll;
      e.secondary_crystal    = w[3];
      e.clock_out = w[2] & (w[1:0] == 2'b11 | w[1:0] == 2'b00);
      e.primary_osc_mode     = owcd_primary_osc_mode_type'(w[1:0]);
      return e;
   endfunction
   function automatic owcd_wdog_type exp_wdog(input logic [15:0] w,
      input logic low_power_rc_osc, input logic s, input logic sw);
      owcd_wdog_type e;
      logic          ok;
      ok = ~low_power_rc_osc & ~s;
      e.clk_src = OWCD_WCLK_LOW_POWER_RC_OSC;
      if (w[11] && w[14:13] == 2'b01) e.clk_src = OWCD_WCLK_SECONDARY_OSC;
      if (w[11] && w[14:13] == 2'b10 && !w[7] && ok)
         e.clk_src = OWCD_WCLK_FRC;
      if (w[11] && w[14:13] == 2'b00 && ok)
         e.clk_src = OWCD_WCLK_PCLK;
      e.run = (w[6:5] == 2'b11) | (w[6:5] == 2'b10 & sw)
            | (w[6:5] == 2'b01 & ~s);
      e.window_en = ~w[7];
      e.window_eighths = (w[9:8] == 2'b00) ? 3'h6
                       : 3'h5 - {1'b0, w[9:8]};
      e.prescale_log2 = w[4] ? 3'h7 : 3'h5;
      e.postscale_log2 = w[3:0];
      e.timeout_log2 = {2'h0, e.prescale_log2} + {1'h0, w[3:0]};
      return e;
   endfunction
   // ***********************
   // checking and bus tasks
   // ***********************
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic end_sim();
      if (fails == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // decode outputs lag inputs by one edge, so look two edges later
   task automatic chk_cfg(input logic sw);
      owcd_osc_type  eo;
      owcd_wdog_type ew;
      repeat (2) @(posedge mclk);
      eo = exp_osc(ow, sys_clk_uses_pll);
      ew = exp_wdog(ww, sys_clk_is_low_power_rc_osc, sleeping, sw);
      chk("osc_cfg", {23'h0, osc_cfg}, {23'h0, eo});
      chk("wdog_cfg", {13'h0, wdog_cfg}, {13'h0, ew});
      chk("cfg_invalid", {31'h0, cfg_invalid},
          {31'h0, ow[4] & (ow[1:0] == 2'b11)});
   endtask
   // classic single cycle; the slave sets the pace
   task automatic bus(input logic we, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] s = 4'hf);
      int n;
      @(posedge mclk);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= a;
      wb_sel <= s;
      wb_dat_w <= d;
      for (n = 0; n < 20 && wb_ack !== 1'b1; n++) @(posedge mclk);
      if (n == 20) begin
         fails++;
         end_sim();
      end
      rd = wb_dat_r;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      wb_we <= 1'b0;
   endtask
   task automatic unlock();
      bus(1'b1, 8'h0c, 32'h55);
      bus(1'b1, 8'h0c, 32'haa);
   endtask
   // status word: loaded, arm state, flags and watchdog decode
   task automatic stat_chk(input logic arm);
      owcd_wdog_type ew;
      ew = exp_wdog(ww, sys_clk_is_low_power_rc_osc, sleeping, 1'b1);
      bus(1'b0, 8'h10, 32'h0);
      chk("status", rd, {25'h0, 1'b1, arm, ow[4] & (ow[1:0] == 2'b11),
          ow[5], ew.run, ew.clk_src});
   endtask
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   // ***********************
   // main sequence
   // ***********************
   initial begin
      {arst_n, nvm_osc_prog, nvm_wdog_prog, sleeping} = 4'h0;
      {sys_clk_is_low_power_rc_osc, sys_clk_uses_pll, wb_cyc, wb_stb, wb_we} = 5'h0;
      {nvm_osc_word, nvm_wdog_word, wb_adr, wb_dat_w} = 72'h0;
      wb_sel = 4'hf;
      fails = 0;
      comparisons = 0;
      void'($urandom(65));
      // first four passes set every two-bit field to each code
      for (int it = 0; it < 14; it++) begin
         @(posedge mclk);
         arst_n <= 1'b0;
         ow = (it < 4) ? {8{it[1:0]}} : 16'($urandom);
         ww = (it < 4) ? {8{it[1:0]}} : 16'($urandom);
         nvm_osc_word <= ow;
         nvm_wdog_word <= ww;
         nvm_osc_prog <= (it < 4) || it[0];
         nvm_wdog_prog <= (it < 4) || it[1];
         if (it >= 4 && !it[0]) ow = 16'hffff;
         if (it >= 4 && !it[1]) ww = 16'hffff;
         repeat (2) @(posedge mclk);
         arst_n <= 1'b1;
         @(posedge mclk);
         chk_cfg(1'b0);
         bus(1'b0, 8'h00, 32'h0);
         chk("osc word", rd, {16'h0, ow});
         bus(1'b1, 8'h04, 32'($urandom));
         bus(1'b0, 8'h04, 32'h0);
         chk("wdog word", rd, {16'h0, ww});
         bus(1'b0, 8'h14, 32'h0);
         chk("unmapped", rd, 32'h0);
         unlock();
         bus(1'b1, 8'h08, 32'h3);
         repeat (2) @(posedge mclk);
         chk("lock set", {31'h0, pin_select_lock}, 32'h1);
         unlock();
         bus(1'b1, 8'h08, 32'h0);
         bus(1'b1, 8'h08, 32'h3);
         repeat (2) @(posedge mclk);
         chk("lock", {31'h0, pin_select_lock}, {31'h0, ow[5]});
         bus(1'b0, 8'h08, 32'h0);
         chk("ctrl", rd, {30'h0, ow[5], ww[6:5] != 2'b00});
         // a wrong key drops the arm; a ctrl write without lane 0 is void
         unlock();
         stat_chk(1'b1);
         bus(1'b1, 8'h0c, 32'h12);
         bus(1'b1, 8'h08, 32'h0, 4'he);
         stat_chk(1'b0);
         bus(1'b0, 8'h08, 32'h0);
         chk("ctrl kept", rd, {30'h0, ow[5], ww[6:5] != 2'b00});
         for (int k = 0; k < 4; k++) begin
            @(posedge mclk);
            {sleeping, sys_clk_is_low_power_rc_osc, sys_clk_uses_pll} <= 3'($urandom);
            chk_cfg(1'b1);
         end
      end
      end_sim();
   end
endmodule
